/* core/iafu_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module iafu_unit (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire iafu_pkg::iafu_req_t req_i,
  output logic done_o,
  output iafu_pkg::iafu_zgl_t zgl_o,
  output logic mem_we_o,
  output logic [31:0] mem_wdata_o,
  output logic trap_emulate_o,
  output logic exp_fault_o,
  output logic div_overflow_o,
  output iafu_pkg::iafu_acc_t acc_o,
  output iafu_pkg::iafu_acc_t save_o
);
  import iafu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] lead_cnt(input logic [47:0] m);
    logic [5:0] n;
    logic hit;
    n = 6'h00;
    hit = 1'b0;
    for (int i = 46; i >= 0; i--) begin
      if (!hit) begin
        if (m[i] != m[47]) begin
          hit = 1'b1;
        end else begin
          n = n + 6'h01;
        end
      end
    end
    return n;
  endfunction

  function automatic iafu_zgl_t sgn48(input logic [47:0] m);
    return '{zero: (m == '0), greater: (!m[47] && m != '0), less: m[47]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  iafu_acc_t acc_ff, save_ff, nxt_acc, nxt_save;
  logic [15:0] xreg_ff [2:7];
  logic [15:0] nxt_x;
  logic x_we;
  iafu_zgl_t zgl_ff, nxt_zgl;
  logic done_ff, we_ff, trap_ff, fault_ff, ovf_ff;
  logic nxt_we, nxt_trap, nxt_fault, nxt_ovf;
  logic [31:0] wdata_ff, nxt_wdata;

  logic is_index, go;
  logic [15:0] xval, xop, xres;
  logic [31:0] fop;
  logic signed [23:0] ma, mb;
  logic signed [EW-1:0] ea, eb, e, ebig;
  logic signed [47:0] m;
  logic signed [48:0] pa, pb, sum;
  logic [5:0] sh;
  logic [47:0] dm, vm;
  logic [70:0] qq, rr;
  logic [23:0] qmag, rmag;
  logic use_add, do_sub, dvd_neg, bad_op;
  logic [47:0] prod;

  assign go = req_valid_i && ce_i;
  assign is_index = !req_i.op[4];
  // Select 1 is the accumulator upper half, so index ops on it act like fixed point.
  assign xval = (req_i.xsel == XSEL_ACC) ? acc_ff.a :
                (req_i.xsel == 3'h0) ? 16'h0000 : xreg_ff[req_i.xsel];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_save = save_ff;
    nxt_acc = acc_ff;
    nxt_x = xval;
    x_we = 1'b0;
    nxt_zgl = zgl_ff;
    nxt_we = 1'b0;
    nxt_wdata = wdata_ff;
    nxt_trap = 1'b0;
    nxt_ovf = 1'b0;
    xres = 16'h0000;
    use_add = 1'b0;
    do_sub = 1'b0;
    pa = '0;
    pb = '0;
    sum = '0;
    m = '0;
    e = '0;
    ebig = '0;
    sh = 6'h00;
    dm = '0;
    vm = '0;
    qq = '0;
    rr = '0;
    qmag = '0;
    rmag = '0;
    prod = '0;
    dvd_neg = 1'b0;
    bad_op = 1'b0;
    // Save happens first, so a save-prefixed op on address one sees the new copy.
    if (req_i.save) begin
      if (is_index) begin
        nxt_save = '{a: xval, ae: acc_ff.ae, af: acc_ff.af, ad: acc_ff.ad};
      end else begin
        nxt_save.a = acc_ff.a;
        nxt_save.af = acc_ff.af;
      end
    end
    if (req_i.literal) begin
      xop = req_i.ea;
    end else if (req_i.ea == ADDR_ACC) begin
      xop = acc_ff.a;
    end else if (req_i.ea == ADDR_SAVE) begin
      xop = nxt_save.a;
    end else begin
      xop = req_i.operand[15:0];
    end
    if (req_i.ea == ADDR_ACC) begin
      fop = {acc_ff.a, acc_ff.af};
    end else if (req_i.ea == ADDR_SAVE) begin
      fop = {nxt_save.a, nxt_save.af};
    end else begin
      fop = req_i.operand;
    end
    if (fop[31:8] == 24'h000000) begin
      fop = 32'h00000000;
    end
    ma = $signed({acc_ff.a, acc_ff.af[15:8]});
    ea = EW'($signed(acc_ff.af[7:0]));
    mb = $signed(fop[31:8]);
    eb = EW'($signed(fop[7:0]));
    unique case (req_i.op)
      OP_INDEX_LOAD: xres = xop;
      OP_INDEX_ADD: xres = xval + xop;
      OP_INDEX_LOAD_NEGATED: xres = 16'h0000 - xop;
      OP_INDEX_SUBTRACT, OP_INDEX_COMPARE: xres = xval - xop;
      OP_INDEX_STORE: xres = xval;
      OP_INDEX_MULTIPLY_EMULATED, OP_INDEX_DIVIDE_EMULATED,
      OP_INDEX_CLEAR_DIVIDE_EMULATED, OP_INDEX_STORE_ROUNDED_EMULATED: nxt_trap = 1'b1;
      OP_FLOAT_ADD, OP_FLOAT_SUBTRACT, OP_FLOAT_COMPARE: begin
        use_add = 1'b1;
        do_sub = (req_i.op != OP_FLOAT_ADD);
        pa = {ma[23], ma, 24'h000000};
        pb = {mb[23], mb, 24'h000000};
        ebig = (ea > eb) ? ea : eb;
      end
      OP_FLOAT_CLEAR_ADD, OP_FLOAT_CLEAR_SUBTRACT: begin
        use_add = 1'b1;
        do_sub = (req_i.op == OP_FLOAT_CLEAR_SUBTRACT);
        pb = {mb[23], mb, 24'h000000};
        ebig = eb;
      end
      OP_FLOAT_STORE_ROUNDED: begin
        // Rounding adds bit 22 of the double section as one low-order unit at the accumulator's exponent.
        use_add = 1'b1;
        pa = {ma[23], ma, 24'h000000};
        pb = {24'h000000, acc_ff.ad[22], 24'h000000};
        eb = ea;
        ebig = ea;
      end
      OP_FLOAT_MULTIPLY: begin
        prod = 48'($signed(ma) * $signed(mb));
        m = $signed({prod[46:0], 1'b0});
        e = ea + eb;
      end
      OP_FLOAT_DIVIDE, OP_FLOAT_CLEAR_DIVIDE: begin
        // Double section is part of the dividend unless clear-divide zeroes it.
        if (req_i.op == OP_FLOAT_CLEAR_DIVIDE) begin
          m = $signed({ma, 24'h000000});
        end else begin
          m = $signed({ma, acc_ff.ad[22:0], 1'b0});
        end
        dvd_neg = m[47];
        dm = m[47] ? 48'h0 - m : m;
        vm = mb[23] ? {24'h0 - mb, 24'h000000} : {mb, 24'h000000};
        nxt_ovf = ({vm, 1'b0} < {1'b0, dm}) || (vm == '0);
        qq = (vm == '0) ? '0 : {dm, 23'h0} / 71'(vm);
        rr = (vm == '0) ? '0 : {dm, 23'h0} % 71'(vm);
        e = ea - eb;
        if (qq[23]) begin
          qmag = {1'b0, qq[23:1]};
          e = e + 10'sd1;
        end else begin
          qmag = qq[23:0];
        end
        rmag = {1'b0, rr[46:24]};
        m = $signed({(dvd_neg != mb[23]) ? 24'h0 - qmag : qmag, 24'h000000});
      end
      OP_FLOAT_STORE: m = $signed({ma, 24'h000000});
      default: bad_op = 1'b1;
    endcase
    if (use_add) begin
      // Alignment shifts of up to 24 places keep the shifted-out bits until the sum is formed.
      pa = pa >>> ((ebig - ea) > 10'sd48 ? 6'd48 : 6'(ebig - ea));
      pb = pb >>> ((ebig - eb) > 10'sd48 ? 6'd48 : 6'(ebig - eb));
      sum = do_sub ? pa - pb : pa + pb;
      e = ebig;
      if (sum[48] != sum[47]) begin
        m = sum[48:1];
        e = e + 10'sd1;
      end else begin
        m = sum[47:0];
      end
    end
    if (!req_i.raw && req_i.op != OP_FLOAT_STORE && !nxt_ovf) begin
      sh = lead_cnt(m);
      m = m <<< sh;
      e = e - EW'(sh);
    end
    if (!(req_i.op inside {OP_FLOAT_STORE_ROUNDED, OP_FLOAT_MULTIPLY})) begin
      m = {m[47:24], 24'h000000};
    end
    if (m[47:24] == 24'h000000 && req_i.op != OP_FLOAT_MULTIPLY) begin
      m = '0;
      e = '0;
    end
    nxt_fault = !is_index && !bad_op && (e < EXP_MIN || e > EXP_MAX) && !nxt_ovf;
    ///////////////////////////////////////////////////////////////////////
    if (is_index && !nxt_trap && !bad_op) begin
      nxt_zgl = sgn48({xres, 32'h0});
      if (req_i.op == OP_INDEX_STORE) begin
        if (req_i.ea == ADDR_ACC) begin
          nxt_acc.a = xval;
        end else begin
          nxt_we = 1'b1;
          nxt_wdata = {16'h0000, xval};
        end
      end else if (req_i.op != OP_INDEX_COMPARE) begin
        nxt_x = xres;
        x_we = 1'b1;
      end
    end else if (!is_index && !bad_op && !nxt_ovf && !nxt_fault) begin
      nxt_zgl = sgn48(m);
      unique case (req_i.op)
        OP_FLOAT_STORE, OP_FLOAT_STORE_ROUNDED: begin
          nxt_we = (req_i.ea != ADDR_ACC);
          nxt_wdata = (req_i.op == OP_FLOAT_STORE) ? {acc_ff.a, acc_ff.af} :
                      {m[47:24], e[7:0]};
        end
        OP_FLOAT_COMPARE: nxt_acc = acc_ff;
        OP_FLOAT_MULTIPLY: begin
          {nxt_acc.a, nxt_acc.af} = {m[47:24], e[7:0]};
          nxt_acc.ad = {1'b0, m[23:1]};
          nxt_acc.ae = 16'h0000;
        end
        OP_FLOAT_DIVIDE, OP_FLOAT_CLEAR_DIVIDE: begin
          {nxt_acc.a, nxt_acc.af} = {m[47:24], e[7:0]};
          nxt_acc.ad = dvd_neg ? 24'h0 - rmag : rmag;
        end
        default: {nxt_acc.a, nxt_acc.af} = {m[47:24], e[7:0]};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_ff <= ACC_RST;
      save_ff <= ACC_RST;
    end else if (go) begin
      save_ff <= nxt_save;
      if (x_we && req_i.xsel == XSEL_ACC) begin
        acc_ff <= '{a: nxt_x, ae: nxt_acc.ae, af: nxt_acc.af, ad: nxt_acc.ad};
      end else begin
        acc_ff <= nxt_acc;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 2; i <= 7; i++) begin
        xreg_ff[i] <= 16'h0000;
      end
    end else if (go && x_we && req_i.xsel > XSEL_ACC) begin
      xreg_ff[req_i.xsel] <= nxt_x;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      zgl_ff <= ZGL_RST;
      done_ff <= 1'b0;
      we_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      trap_ff <= 1'b0;
      fault_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else if (ce_i) begin
      done_ff <= req_valid_i;
      we_ff <= go && nxt_we;
      trap_ff <= go && nxt_trap;
      fault_ff <= go && nxt_fault;
      ovf_ff <= go && nxt_ovf;
      if (go) begin
        zgl_ff <= nxt_zgl;
        wdata_ff <= nxt_wdata;
      end
    end
  end

  assign done_o = done_ff;
  assign zgl_o = zgl_ff;
  assign mem_we_o = we_ff;
  assign mem_wdata_o = wdata_ff;
  assign trap_emulate_o = trap_ff;
  assign exp_fault_o = fault_ff;
  assign div_overflow_o = ovf_ff;
  assign acc_o = acc_ff;
  assign save_o = save_ff;
endmodule
`default_nettype wire

/* core/iafu_pkg.sv */
package iafu_pkg;
  localparam int XW = 16;
  localparam int MW = 24;
  localparam int EW = 10;
  localparam logic [15:0] ADDR_ACC = 16'h0000;
  localparam logic [15:0] ADDR_SAVE = 16'h0001;
  localparam logic [2:0] XSEL_ACC = 3'h1;
  localparam logic signed [EW-1:0] EXP_MIN = -10'sd128;
  localparam logic signed [EW-1:0] EXP_MAX = 10'sd127;
  localparam logic [2:0] ZGL_RST = 3'h0;

  typedef enum logic [4:0] {
    OP_INDEX_LOAD = 5'h00,
    OP_INDEX_ADD = 5'h01,
    OP_INDEX_LOAD_NEGATED = 5'h02,
    OP_INDEX_SUBTRACT = 5'h03,
    OP_INDEX_COMPARE = 5'h04,
    OP_INDEX_STORE = 5'h05,
    OP_INDEX_MULTIPLY_EMULATED = 5'h06,
    OP_INDEX_DIVIDE_EMULATED = 5'h07,
    OP_INDEX_CLEAR_DIVIDE_EMULATED = 5'h08,
    OP_INDEX_STORE_ROUNDED_EMULATED = 5'h09,
    OP_FLOAT_ADD = 5'h10,
    OP_FLOAT_SUBTRACT = 5'h11,
    OP_FLOAT_MULTIPLY = 5'h12,
    OP_FLOAT_DIVIDE = 5'h13,
    OP_FLOAT_CLEAR_ADD = 5'h14,
    OP_FLOAT_CLEAR_SUBTRACT = 5'h15,
    OP_FLOAT_COMPARE = 5'h16,
    OP_FLOAT_STORE = 5'h17,
    OP_FLOAT_STORE_ROUNDED = 5'h18,
    OP_FLOAT_CLEAR_DIVIDE = 5'h19
  } iafu_op_t;

  // Accumulator sections; a holds the upper half, af the float section.
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] ae;
    logic [15:0] af;
    logic [23:0] ad;
  } iafu_acc_t;

  localparam iafu_acc_t ACC_RST = '0;

  typedef struct packed {
    iafu_op_t op;
    logic raw;
    logic save;
    logic literal;
    logic [2:0] xsel;
    logic [15:0] ea;
    logic [31:0] operand;
  } iafu_req_t;

  typedef struct packed {
    logic zero;
    logic greater;
    logic less;
  } iafu_zgl_t;
endpackage

/* tb/iafu_unit_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module iafu_unit_asserts (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  input wire iafu_pkg::iafu_req_t req_i,
  input wire logic done_o,
  input wire iafu_pkg::iafu_zgl_t zgl_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic trap_emulate_o,
  input wire logic exp_fault_o,
  input wire logic div_overflow_o,
  input wire iafu_pkg::iafu_acc_t acc_o,
  input wire iafu_pkg::iafu_acc_t save_o
);
  import iafu_pkg::*;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  wire logic go = ce_i && req_valid_i;
  wire logic xop = req_i.op inside {OP_INDEX_LOAD, OP_INDEX_ADD, OP_INDEX_LOAD_NEGATED,
    OP_INDEX_SUBTRACT, OP_INDEX_COMPARE};
  wire logic emu = req_i.op inside {OP_INDEX_MULTIPLY_EMULATED, OP_INDEX_DIVIDE_EMULATED,
    OP_INDEX_CLEAR_DIVIDE_EMULATED, OP_INDEX_STORE_ROUNDED_EMULATED};
  wire logic dv = go && req_i.op inside {OP_FLOAT_DIVIDE, OP_FLOAT_CLEAR_DIVIDE};
  ////////////////////////////////////////////////////////////////////////////////
  a_emul_trap: assert property (go && emu |=> trap_emulate_o && !mem_we_o)
    else $error("emulated op did not trap");
  a_xsel_acc: assert property (go && req_i.op == OP_INDEX_LOAD && req_i.xsel == XSEL_ACC
    && !req_i.literal && !req_i.save && req_i.ea > ADDR_SAVE
    |=> acc_o.a == $past(req_i.operand[15:0])) else $error("register one missed acc");
  a_xsave_keep: assert property (go && xop && req_i.save && req_i.xsel != XSEL_ACC
    |=> acc_o == $past(acc_o) && save_o.ad == $past(acc_o.ad)) else $error("index save wrong");
  a_xstore_acc: assert property (go && req_i.op == OP_INDEX_STORE && req_i.ea == ADDR_ACC
    |=> !mem_we_o) else $error("store to acc wrote memory");
  a_fstore_raw: assert property (go && req_i.op == OP_FLOAT_STORE && req_i.ea > ADDR_SAVE
    |=> mem_we_o && mem_wdata_o == {$past(acc_o.a), $past(acc_o.af)})
    else $error("float store altered word");
  a_fault_hold: assert property (exp_fault_o || div_overflow_o |-> $stable(acc_o))
    else $error("fault changed acc");
  a_fmul_sign: assert property (go && req_i.op == OP_FLOAT_MULTIPLY
    |=> exp_fault_o || !acc_o.ad[23]) else $error("product sign bit set");
  a_ovf_cause: assert property ($rose(div_overflow_o) |-> $past(dv))
    else $error("overflow without divide");
  c_mult: cover property (go && req_i.op == OP_FLOAT_MULTIPLY);
  c_fault: cover property (exp_fault_o);
  c_ovf: cover property (div_overflow_o);
endmodule
bind iafu_unit iafu_unit_asserts u_asserts (.clock_i, .resetn_i, .ce_i, .req_valid_i, .req_i,
  .done_o, .zgl_o, .mem_we_o, .mem_wdata_o, .trap_emulate_o, .exp_fault_o, .div_overflow_o,
  .acc_o, .save_o);
`default_nettype wire

/* tb/iafu_core_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module iafu_core_mem (
  input wire logic clock_i,
  input wire logic take_i,
  input wire logic [15:0] ea_i,
  input wire logic we_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [16];
  logic [3:0] wa_ff;
  assign rdata_o = mem[ea_i[3:0]];
  // Store data leaves one cycle after its request, so the address is kept from that edge.
  always @(posedge clock_i) begin
    if (take_i) wa_ff <= ea_i[3:0];
    if (we_i) mem[wa_ff] <= wdata_i;
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import iafu_pkg::*;
  typedef struct packed {
    iafu_op_t op;
    logic [2:0] f;
    logic [2:0] x;
    logic [15:0] ea;
    logic [31:0] d;
    logic [2:0] z;
    logic [1:0] k;
    logic [31:0] w;
  } iafu_row_t;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b0;
  logic req_valid_i = 1'b0;
  iafu_req_t cmd = '0;
  iafu_req_t req_w;
  logic [31:0] rdata;
  logic done_o, mem_we_o, trap_emulate_o, exp_fault_o, div_overflow_o;
  logic [31:0] mem_wdata_o;
  iafu_zgl_t zgl_o;
  iafu_acc_t acc_o, save_o;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  iafu_op_t emu[4] = '{OP_INDEX_MULTIPLY_EMULATED, OP_INDEX_DIVIDE_EMULATED,
    OP_INDEX_CLEAR_DIVIDE_EMULATED, OP_INDEX_STORE_ROUNDED_EMULATED};
  // Field f is {raw, save, literal}; stores never use the literal form.
  iafu_row_t rows[14] = '{
    '{OP_INDEX_LOAD, 3'h1, 3'h3, 16'h0005, 32'h0, 3'h2, 2'h0, 32'h0},
    '{OP_INDEX_ADD, 3'h0, 3'h3, 16'h0002, 32'h0000_fffa, 3'h1, 2'h0, 32'h0},
    '{OP_INDEX_STORE, 3'h0, 3'h3, 16'h0003, 32'h5a5a_5a5a, 3'h1, 2'h2, 32'h0000_ffff},
    '{OP_INDEX_LOAD_NEGATED, 3'h0, 3'h3, 16'h0004, 32'h7, 3'h1, 2'h0, 32'h0},
    '{OP_INDEX_SUBTRACT, 3'h1, 3'h3, 16'hfff9, 32'h0, 3'h4, 2'h0, 32'h0},
    '{OP_INDEX_COMPARE, 3'h0, 3'h3, 16'h0005, 32'h1, 3'h1, 2'h0, 32'h0},
    '{OP_FLOAT_CLEAR_ADD, 3'h4, 3'h0, 16'h0008, 32'h0040_0001, 3'h2, 2'h1, 32'h0040_0001},
    '{OP_FLOAT_STORE, 3'h4, 3'h0, 16'h0009, 32'h5a5a_5a5a, 3'h2, 2'h2, 32'h0040_0001},
    '{OP_FLOAT_CLEAR_ADD, 3'h0, 3'h0, 16'h0008, 32'h0040_0001, 3'h2, 2'h1, 32'h4000_00f9},
    '{OP_FLOAT_CLEAR_ADD, 3'h4, 3'h0, 16'h000a, 32'h4000_0002, 3'h2, 2'h1, 32'h4000_0002},
    '{OP_FLOAT_ADD, 3'h0, 3'h0, 16'h000b, 32'h4000_0001, 3'h2, 2'h1, 32'h6000_0002},
    '{OP_FLOAT_SUBTRACT, 3'h4, 3'h0, 16'h000d, 32'h4000_0002, 3'h2, 2'h1, 32'h2000_0002},
    '{OP_FLOAT_CLEAR_ADD, 3'h0, 3'h0, 16'h000c, 32'h5, 3'h4, 2'h1, 32'h0},
    '{OP_FLOAT_CLEAR_SUBTRACT, 3'h0, 3'h0, 16'h0002, 32'h6000_0001, 3'h1, 2'h1, 32'ha000_0001}};
  iafu_unit u_dut (.clock_i, .resetn_i, .ce_i, .req_valid_i, .req_i(req_w), .done_o, .zgl_o,
    .mem_we_o, .mem_wdata_o, .trap_emulate_o, .exp_fault_o, .div_overflow_o, .acc_o, .save_o);
  iafu_core_mem u_mem (.clock_i, .take_i(ce_i && req_valid_i), .ea_i(cmd.ea), .we_i(mem_we_o),
    .wdata_i(mem_wdata_o), .rdata_o(rdata));
  always_comb begin
    req_w = cmd;
    req_w.operand = rdata;
  end
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 500) begin
      num_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic go(input iafu_op_t op, input logic [2:0] f, input logic [2:0] x,
      input logic [15:0] ea, input logic [31:0] d);
    if (!f[0] && ea > ADDR_SAVE) u_mem.mem[ea[3:0]] = d;
    cmd = '{op, f[2], f[1], f[0], x, ea, 32'h0};
    req_valid_i = 1'b1;
    @(posedge clock_i);
    #1;
    chk(done_o, 1'b1, "done");
  endtask
  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    ce_i = 1'b1;
    chk(acc_o, ACC_RST, "acc reset");
    chk(zgl_o, ZGL_RST, "flags reset");
    foreach (rows[i]) begin
      go(rows[i].op, rows[i].f, rows[i].x, rows[i].ea, rows[i].d);
      chk(zgl_o, rows[i].z, "flags");
      if (rows[i].k == 2'h1) chk({acc_o.a, acc_o.af}, rows[i].w, "float word");
      if (rows[i].k == 2'h2) chk({mem_we_o, mem_wdata_o}, {1'b1, rows[i].w}, "store");
    end
    foreach (emu[i]) begin
      go(emu[i], 3'h0, 3'h3, 16'h0002, 32'h1);
      chk({trap_emulate_o, mem_we_o, zgl_o}, {1'b1, 1'b0, 3'h1}, "emulated");
    end
    go(OP_INDEX_LOAD, 3'h0, XSEL_ACC, 16'h0002, 32'h1234);
    chk(acc_o.a, 16'h1234, "register one");
    go(OP_INDEX_LOAD, 3'h1, 3'h5, 16'h0042, 32'h0);
    go(OP_INDEX_ADD, 3'h0, 3'h5, ADDR_ACC, 32'h0);
    go(OP_INDEX_STORE, 3'h0, 3'h5, ADDR_ACC, 32'h0);
    chk({mem_we_o, acc_o.a}, {1'b0, 16'h1276}, "store to acc");
    go(OP_INDEX_LOAD, 3'h3, 3'h5, 16'h0007, 32'h0);
    chk({save_o.a, acc_o.a, save_o.af}, {16'h1276, 16'h1276, 16'h0001}, "index save");
    go(OP_INDEX_STORE, 3'h0, 3'h5, ADDR_SAVE, 32'h0);
    chk({mem_we_o, mem_wdata_o}, {1'b1, 32'h7}, "store ea one");
    go(OP_INDEX_SUBTRACT, 3'h0, 3'h5, ADDR_SAVE, 32'h0);
    go(OP_INDEX_STORE, 3'h0, 3'h5, ADDR_ACC, 32'h0);
    chk(acc_o.a, 16'hed91, "save operand");
    go(OP_FLOAT_CLEAR_ADD, 3'h6, 3'h0, 16'h000e, 32'h6000_0100);
    chk({save_o.a, save_o.af}, {16'hed91, 16'h0001}, "float save");
    go(OP_FLOAT_MULTIPLY, 3'h0, 3'h0, 16'h000f, 32'h6000_0000);
    chk({acc_o.a, acc_o.af, acc_o.ad}, {32'h4800_0000, 24'h60_0000}, "product");
    go(OP_FLOAT_STORE_ROUNDED, 3'h0, 3'h0, 16'h0007, 32'h5a5a_5a5a);
    chk(mem_wdata_o, 32'h4800_0100, "rounded");
    go(OP_FLOAT_CLEAR_DIVIDE, 3'h0, 3'h0, 16'h000f, 32'h6000_0000);
    chk({acc_o.a, acc_o.af, acc_o.ad}, {32'h6000_0000, 24'h0}, "quotient");
    go(OP_FLOAT_COMPARE, 3'h0, 3'h0, 16'h000f, 32'h6000_0000);
    chk(zgl_o, 3'h4, "compare");
    go(OP_FLOAT_DIVIDE, 3'h0, 3'h0, 16'h000c, 32'h1000_0000);
    chk({div_overflow_o, acc_o.a}, {1'b1, 16'h6000}, "overflow");
    go(OP_FLOAT_CLEAR_ADD, 3'h4, 3'h0, 16'h000c, 32'h4000_007f);
    go(OP_FLOAT_MULTIPLY, 3'h0, 3'h0, 16'h000d, 32'h4000_007f);
    chk({exp_fault_o, acc_o.af}, {1'b1, 16'h007f}, "fault");
    // With the clock enable low a request is ignored and every output holds.
    ce_i = 1'b0;
    go(OP_INDEX_LOAD, 3'h1, XSEL_ACC, 16'h0033, 32'h0);
    chk({exp_fault_o, acc_o.a}, {1'b1, 16'h4000}, "frozen");
    resetn_i = 1'b0;
    #1;
    chk(acc_o, ACC_RST, "acc mid reset");
    chk(save_o, ACC_RST, "save mid reset");
    chk({done_o, mem_we_o, trap_emulate_o, exp_fault_o, div_overflow_o, zgl_o}, 8'h00, "outs");
    @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    ce_i = 1'b1;
    go(OP_INDEX_ADD, 3'h1, 3'h5, 16'h0001, 32'h0);
    go(OP_INDEX_STORE, 3'h0, 3'h5, ADDR_ACC, 32'h0);
    chk({zgl_o, acc_o.a}, {3'h2, 16'h0001}, "index after reset");
    go(iafu_op_t'(5'h1f), 3'h0, 3'h0, 16'h000c, 32'h4000_0001);
    chk({zgl_o, acc_o.a, acc_o.af}, {3'h2, 16'h0001, 16'h0000}, "unknown op");
    req_valid_i = 1'b0;
    repeat (2) @(posedge clock_i);
    conclude();
  end
endmodule
`default_nettype wire
